// ### design/sma_pkg.sv
// shared constants and types of the smbus status and address-match block
package sma_pkg;
  localparam int SMA_CLK_MHZ = 200;
  localparam int SMA_HALF_NS = 1250;
  localparam logic [9:0] SMA_HALF_CYC = 10'((SMA_HALF_NS * SMA_CLK_MHZ + 999) / 1000);

  localparam logic [2:0] SMA_A_CTRL = 3'h0;
  localparam logic [2:0] SMA_A_DATA = 3'h1;
  localparam logic [2:0] SMA_A_OWN = 3'h2;
  localparam logic [2:0] SMA_A_MASK = 3'h3;
  localparam logic [2:0] SMA_A_STAT = 3'h4;

  localparam int SMA_C_SIF = 0;
  localparam int SMA_C_ACK = 1;
  localparam int SMA_C_END = 4;
  localparam int SMA_C_BEGIN = 5;
  localparam int SMA_LOW_BIT = 0;

  localparam logic [3:0] SMA_SV_IDLE = 4'h0;
  localparam logic [3:0] SMA_SV_SSTOP = 4'h1;
  localparam logic [3:0] SMA_SV_SADDR = 4'h2;
  localparam logic [3:0] SMA_SV_MRX = 4'h8;
  localparam logic [3:0] SMA_SV_MTX = 4'hC;
  localparam logic [3:0] SMA_SV_MSTART = 4'hE;
  localparam logic [6:0] SMA_GC_ADDR = 7'h00;
  localparam logic [3:0] SMA_ACK_BIT = 4'h8;
  localparam logic [3:0] SMA_LAST_BIT = 4'h7;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ST_SDA, ST_HOLD, ST_DECIDE, ST_BIT_LO, ST_BIT_HI, ST_RS_LO, ST_RS_HI,
    ST_STOP_LO, ST_STOP_HI, ST_STOP_END, ST_SLV_BIT, ST_SLV_HOLD, ST_SLV_ACK, ST_SLV_ON
  } sma_fsm_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sma_bus_req_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } sma_pin_out_t;

  typedef struct packed {
    sma_fsm_t fsm;
    logic [9:0] cnt;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [3:0] sv;
    logic [6:0] own_address_field;
    logic [6:0] address_mask_field;
    logic general_call_enable;
    logic hw_ack_enable;
    logic serial_interrupt_flag;
    logic arbitration_lost_flag;
    logic ack_request_flag;
    logic ack_flag;
    logic begin_condition_request;
    logic end_condition_request;
    logic tx_loaded;
    logic rx_mode;
    logic ack_pend;
    logic restart;
    logic seen_hi;
    logic slv_acked;
    logic master;
    logic busy;
    logic scl_drv;
    logic sda_drv;
    logic pin_lvl;
    logic [7:0] rd_data;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } sma_state_t;

  localparam sma_state_t SMA_STATE_RST = '{fsm: ST_IDLE, scl_m: 1'b1, scl_s: 1'b1,
    scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1, default: '0};
endpackage

// ### design/sma_smbus_core.sv
// smbus status flags, slave address match and master transmit sequencing
`timescale 1ns/10ps
module sma_smbus_core (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input sma_pkg::sma_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output sma_pkg::sma_pin_out_t pins
);
  import sma_pkg::*;

  sma_state_t s_r;
  sma_state_t s_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic samp;
  logic hi_end;
  logic sw_clear;

  function automatic logic addr_match(input logic [7:0] rx, input logic [6:0] own,
                                      input logic [6:0] mask, input logic gc);
    addr_match = (((rx[7:1] ^ own) & mask) == 7'h00)
                 || (gc && rx[7:1] == SMA_GC_ADDR);
  endfunction

  assign scl_rise = s_r.scl_s & ~s_r.scl_d;
  assign scl_fall = ~s_r.scl_s & s_r.scl_d;
  assign start_det = s_r.scl_s & s_r.scl_d & ~s_r.sda_s & s_r.sda_d;
  assign stop_det = s_r.scl_s & s_r.scl_d & s_r.sda_s & ~s_r.sda_d;
  // first high cycle of a bit, after any clock stretching by others
  assign samp = (s_r.fsm == ST_BIT_HI) && s_r.scl_s && (s_r.cnt == SMA_HALF_CYC);
  assign hi_end = (s_r.fsm == ST_BIT_HI) && s_r.scl_s && (s_r.cnt == 10'h000);
  assign sw_clear = bus_req.wr && bus_req.addr == SMA_A_CTRL && !bus_req.wdata[SMA_C_SIF];

  always_comb begin
    logic lose;
    logic [7:0] rmux;
    lose = 1'b0;
    rmux = 8'h00;
    s_nxt = s_r;
    s_nxt.scl_m = scl_i;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_d = s_r.scl_s;
    s_nxt.sda_m = sda_i;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_d = s_r.sda_s;
    if (start_det) begin
      s_nxt.busy = 1'b1;
    end
    if (stop_det) begin
      s_nxt.busy = 1'b0;
    end

    case (bus_req.addr)
      SMA_A_CTRL: rmux = {2'b00, s_r.begin_condition_request, s_r.end_condition_request,
                          s_r.ack_request_flag, s_r.arbitration_lost_flag, s_r.ack_flag,
                          s_r.serial_interrupt_flag};
      SMA_A_DATA: rmux = s_r.shreg;
      SMA_A_OWN: rmux = {s_r.own_address_field, s_r.general_call_enable};
      SMA_A_MASK: rmux = {s_r.address_mask_field, s_r.hw_ack_enable};
      SMA_A_STAT: rmux = {s_r.master, s_r.busy, 2'b00, s_r.sv};
      default: rmux = 8'h00;
    endcase
    s_nxt.rd_data = bus_req.rd ? rmux : 8'h00;

    if (bus_req.wr) begin
      case (bus_req.addr)
        SMA_A_CTRL: begin
          // software may only clear the flag; writing one keeps it
          if (sw_clear) begin
            s_nxt.serial_interrupt_flag = 1'b0;
            s_nxt.arbitration_lost_flag = 1'b0;
          end
          s_nxt.ack_flag = bus_req.wdata[SMA_C_ACK];
          s_nxt.begin_condition_request = bus_req.wdata[SMA_C_BEGIN];
          s_nxt.end_condition_request = bus_req.wdata[SMA_C_END];
        end
        SMA_A_DATA: begin
          s_nxt.shreg = bus_req.wdata;
          s_nxt.tx_loaded = 1'b1;
        end
        SMA_A_OWN: begin
          s_nxt.own_address_field = bus_req.wdata[7:1];
          s_nxt.general_call_enable = bus_req.wdata[SMA_LOW_BIT];
        end
        SMA_A_MASK: begin
          s_nxt.address_mask_field = bus_req.wdata[7:1];
          s_nxt.hw_ack_enable = bus_req.wdata[SMA_LOW_BIT];
        end
        default: ;
      endcase
    end

    // hardware updates follow the register write so a set wins over a clear
    unique case (s_r.fsm)
      ST_IDLE: begin
        s_nxt.scl_drv = 1'b0;
        s_nxt.sda_drv = 1'b0;
        if (s_r.begin_condition_request && !s_r.serial_interrupt_flag && !s_r.busy) begin
          s_nxt.fsm = ST_ST_SDA;
          s_nxt.sda_drv = 1'b1;
          s_nxt.cnt = SMA_HALF_CYC;
          s_nxt.master = 1'b1;
        end else if (start_det) begin
          s_nxt.fsm = ST_SLV_BIT;
          s_nxt.bitn = 4'h0;
          s_nxt.slv_acked = 1'b0;
        end
      end
      ST_ST_SDA: begin
        if (s_r.cnt == 10'h000) begin
          s_nxt.scl_drv = 1'b1;
          s_nxt.serial_interrupt_flag = 1'b1;
          s_nxt.sv = SMA_SV_MSTART;
          s_nxt.fsm = ST_HOLD;
        end else begin
          s_nxt.cnt = s_r.cnt - 10'h001;
        end
      end
      ST_HOLD: begin
        s_nxt.scl_drv = 1'b1;
        if (!s_r.serial_interrupt_flag) begin
          s_nxt.cnt = SMA_HALF_CYC;
          s_nxt.fsm = s_r.ack_pend ? ST_BIT_LO : ST_DECIDE;
          s_nxt.ack_pend = 1'b0;
        end
      end
      ST_DECIDE: begin
        s_nxt.cnt = SMA_HALF_CYC;
        if (s_r.begin_condition_request && s_r.end_condition_request) begin
          s_nxt.fsm = ST_STOP_LO;
          s_nxt.restart = 1'b1;
        end else if (s_r.end_condition_request) begin
          s_nxt.fsm = ST_STOP_LO;
        end else if (s_r.begin_condition_request) begin
          s_nxt.fsm = ST_RS_LO;
        end else if (s_r.tx_loaded) begin
          s_nxt.tx_loaded = 1'b0;
          s_nxt.rx_mode = 1'b0;
          s_nxt.bitn = 4'h0;
          s_nxt.fsm = ST_BIT_LO;
        end else begin
          s_nxt.rx_mode = 1'b1;
          s_nxt.bitn = 4'h0;
          s_nxt.sv = SMA_SV_MRX;
          s_nxt.fsm = ST_BIT_LO;
        end
      end
      ST_BIT_LO: begin
        s_nxt.scl_drv = 1'b1;
        s_nxt.sda_drv = (s_r.bitn == SMA_ACK_BIT) ? (s_r.rx_mode & s_r.ack_flag)
                                                  : (!s_r.rx_mode & !s_r.shreg[7]);
        if (start_det && !s_r.begin_condition_request) begin
          lose = 1'b1;
        end else if (s_r.cnt == 10'h000) begin
          s_nxt.scl_drv = 1'b0;
          s_nxt.cnt = SMA_HALF_CYC;
          s_nxt.fsm = ST_BIT_HI;
        end else begin
          s_nxt.cnt = s_r.cnt - 10'h001;
        end
      end
      ST_BIT_HI: begin
        if (start_det && !s_r.begin_condition_request) begin
          lose = 1'b1;
        end else if (samp && s_r.bitn == SMA_ACK_BIT) begin
          if (!s_r.rx_mode) begin
            s_nxt.ack_flag = !s_r.sda_s;
          end
        end else if (samp && s_r.rx_mode) begin
          s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s};
        end else if (samp && s_r.shreg[7] && !s_r.sda_s) begin
          lose = 1'b1;
        end
        if (s_r.scl_s && !lose) begin
          s_nxt.cnt = s_r.cnt - 10'h001;
        end
        if (hi_end && !lose) begin
          s_nxt.scl_drv = 1'b1;
          s_nxt.cnt = SMA_HALF_CYC;
          if (s_r.bitn == SMA_ACK_BIT) begin
            s_nxt.sda_drv = 1'b0;
            if (s_r.rx_mode) begin
              s_nxt.ack_request_flag = 1'b0;
            end
            if (s_r.rx_mode && !s_r.hw_ack_enable) begin
              s_nxt.fsm = ST_DECIDE;
            end else begin
              s_nxt.serial_interrupt_flag = 1'b1;
              s_nxt.sv = s_r.rx_mode ? SMA_SV_MRX : SMA_SV_MTX;
              s_nxt.fsm = ST_HOLD;
            end
          end else if (s_r.bitn == SMA_LAST_BIT && s_r.rx_mode && !s_r.hw_ack_enable) begin
            s_nxt.bitn = SMA_ACK_BIT;
            s_nxt.sda_drv = 1'b0;
            s_nxt.serial_interrupt_flag = 1'b1;
            s_nxt.ack_request_flag = 1'b1;
            s_nxt.ack_pend = 1'b1;
            s_nxt.sv = SMA_SV_MRX;
            s_nxt.fsm = ST_HOLD;
          end else begin
            s_nxt.bitn = s_r.bitn + 4'h1;
            if (!s_r.rx_mode) begin
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            end
            s_nxt.fsm = ST_BIT_LO;
          end
        end
      end
      ST_RS_LO, ST_STOP_LO: begin
        s_nxt.scl_drv = 1'b1;
        s_nxt.sda_drv = (s_r.fsm == ST_STOP_LO);
        if (s_r.cnt == 10'h000) begin
          s_nxt.scl_drv = 1'b0;
          s_nxt.cnt = SMA_HALF_CYC;
          s_nxt.seen_hi = 1'b0;
          s_nxt.fsm = (s_r.fsm == ST_STOP_LO) ? ST_STOP_HI : ST_RS_HI;
        end else begin
          s_nxt.cnt = s_r.cnt - 10'h001;
        end
      end
      ST_RS_HI, ST_STOP_HI: begin
        if (s_r.scl_s) begin
          s_nxt.seen_hi = 1'b1;
        end
        if (s_r.seen_hi && !s_r.scl_s) begin
          lose = 1'b1;
        end else if (s_r.scl_s && s_r.cnt == 10'h000) begin
          s_nxt.cnt = SMA_HALF_CYC;
          s_nxt.sda_drv = (s_r.fsm == ST_RS_HI);
          s_nxt.fsm = (s_r.fsm == ST_RS_HI) ? ST_ST_SDA : ST_STOP_END;
        end else if (s_r.scl_s) begin
          s_nxt.cnt = s_r.cnt - 10'h001;
        end
      end
      ST_STOP_END: begin
        if (s_r.cnt != 10'h000) begin
          s_nxt.cnt = s_r.cnt - 10'h001;
        end else if (s_r.restart) begin
          s_nxt.restart = 1'b0;
          s_nxt.sda_drv = 1'b1;
          s_nxt.cnt = SMA_HALF_CYC;
          s_nxt.fsm = ST_ST_SDA;
        end else begin
          s_nxt.master = 1'b0;
          s_nxt.sv = SMA_SV_IDLE;
          s_nxt.fsm = ST_IDLE;
        end
      end
      ST_SLV_BIT: begin
        if (scl_rise) begin
          s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s};
          s_nxt.bitn = s_r.bitn + 4'h1;
        end
        if (stop_det) begin
          s_nxt.fsm = ST_IDLE;
        end else if (start_det) begin
          s_nxt.bitn = 4'h0;
        end else if (scl_fall && s_r.bitn == SMA_ACK_BIT) begin
          if (s_r.hw_ack_enable) begin
            if (addr_match(s_r.shreg, s_r.own_address_field, s_r.address_mask_field,
                           s_r.general_call_enable)) begin
              s_nxt.sda_drv = 1'b1;
              s_nxt.fsm = ST_SLV_ACK;
            end else begin
              s_nxt.fsm = ST_IDLE;
            end
          end else begin
            s_nxt.serial_interrupt_flag = 1'b1;
            s_nxt.ack_request_flag = 1'b1;
            s_nxt.sv = SMA_SV_SADDR;
            s_nxt.scl_drv = 1'b1;
            s_nxt.fsm = ST_SLV_HOLD;
          end
        end
      end
      ST_SLV_HOLD: begin
        s_nxt.scl_drv = 1'b1;
        if (!s_r.serial_interrupt_flag) begin
          s_nxt.scl_drv = 1'b0;
          if (s_r.slv_acked) begin
            s_nxt.fsm = ST_SLV_ON;
          end else if (s_r.ack_flag) begin
            s_nxt.sda_drv = 1'b1;
            s_nxt.fsm = ST_SLV_ACK;
          end else begin
            s_nxt.ack_request_flag = 1'b0;
            s_nxt.fsm = ST_IDLE;
          end
        end
      end
      ST_SLV_ACK: begin
        if (scl_fall) begin
          s_nxt.sda_drv = 1'b0;
          s_nxt.ack_request_flag = 1'b0;
          s_nxt.slv_acked = 1'b1;
          if (s_r.hw_ack_enable) begin
            s_nxt.serial_interrupt_flag = 1'b1;
            s_nxt.sv = SMA_SV_SADDR;
            s_nxt.scl_drv = 1'b1;
            s_nxt.fsm = ST_SLV_HOLD;
          end else begin
            s_nxt.fsm = ST_SLV_ON;
          end
        end
      end
      ST_SLV_ON: begin
        if (stop_det) begin
          s_nxt.serial_interrupt_flag = 1'b1;
          s_nxt.sv = SMA_SV_SSTOP;
          s_nxt.fsm = ST_IDLE;
        end else if (start_det) begin
          s_nxt.bitn = 4'h0;
          s_nxt.slv_acked = 1'b0;
          s_nxt.fsm = ST_SLV_BIT;
        end
      end
    endcase

    if (lose) begin
      // release both lines at once so the winning master is not disturbed
      s_nxt.serial_interrupt_flag = 1'b1;
      s_nxt.arbitration_lost_flag = 1'b1;
      s_nxt.scl_drv = 1'b0;
      s_nxt.sda_drv = 1'b0;
      s_nxt.master = 1'b0;
      s_nxt.restart = 1'b0;
      s_nxt.sv = SMA_SV_IDLE;
      s_nxt.fsm = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= SMA_STATE_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd_data;
  assign pins = '{scl_o: s_r.pin_lvl, scl_oe: s_r.scl_drv, sda_o: s_r.pin_lvl,
                  sda_oe: s_r.sda_drv};

  property p_arb_clr;
    @(posedge clk) disable iff (!rst_n) $fell(s_r.serial_interrupt_flag) |->
      !s_r.arbitration_lost_flag;
  endproperty
  a_arb_clr: assert property (p_arb_clr) else $error("arbitration flag outlived clear");

  property p_sif_kept;
    @(posedge clk) disable iff (!rst_n) s_r.serial_interrupt_flag && !(ce && sw_clear) |=>
      s_r.serial_interrupt_flag;
  endproperty
  a_sif_kept: assert property (p_sif_kept) else $error("interrupt flag dropped by hw");

  property p_hold;
    @(posedge clk) disable iff (!rst_n) s_r.fsm == ST_HOLD && s_r.serial_interrupt_flag |=>
      s_r.fsm == ST_HOLD && s_r.scl_drv;
  endproperty
  a_hold: assert property (p_hold) else $error("bus not held while flag set");

  property p_ack_sample;
    @(posedge clk) disable iff (!rst_n) ce && samp && s_r.bitn == SMA_ACK_BIT && !s_r.rx_mode
      |=> s_r.ack_flag == !$past(s_r.sda_s);
  endproperty
  a_ack_sample: assert property (p_ack_sample) else $error("ack bit wrong");

  property p_sda_lost;
    @(posedge clk) disable iff (!rst_n) ce && samp && !s_r.rx_mode && s_r.bitn != SMA_ACK_BIT
      && s_r.shreg[7] && !s_r.sda_s |=> s_r.arbitration_lost_flag && s_r.fsm == ST_IDLE
      && !s_r.sda_drv;
  endproperty
  a_sda_lost: assert property (p_sda_lost) else $error("sda loss missed");

  property p_scl_lost;
    @(posedge clk) disable iff (!rst_n) ce && (s_r.fsm == ST_RS_HI || s_r.fsm == ST_STOP_HI)
      && s_r.seen_hi && !s_r.scl_s |=> s_r.arbitration_lost_flag && s_r.serial_interrupt_flag;
  endproperty
  a_scl_lost: assert property (p_scl_lost) else $error("scl loss missed");

  property p_start_vec;
    @(posedge clk) disable iff (!rst_n) ce && s_r.fsm == ST_ST_SDA && s_r.cnt == 10'h000 |=>
      s_r.sv == SMA_SV_MSTART && s_r.serial_interrupt_flag && s_r.sda_drv && s_r.scl_drv;
  endproperty
  a_start_vec: assert property (p_start_vec) else $error("start status wrong");

  property p_to_rx;
    @(posedge clk) disable iff (!rst_n) ce && s_r.fsm == ST_DECIDE && !s_r.tx_loaded
      && !s_r.begin_condition_request && !s_r.end_condition_request |=>
      s_r.rx_mode && s_r.sv == SMA_SV_MRX && s_r.fsm == ST_BIT_LO;
  endproperty
  a_to_rx: assert property (p_to_rx) else $error("receiver switch missing");

  property p_ack_request_flag;
    @(posedge clk) disable iff (!rst_n) $rose(s_r.ack_request_flag) |->
      s_r.serial_interrupt_flag && !s_r.hw_ack_enable;
  endproperty
  a_ack_request_flag: assert property (p_ack_request_flag) else $error("ack request in hw ack mode");

  property p_mask_example;
    @(posedge clk) disable iff (!rst_n)
      addr_match(8'h6A, 7'h34, 7'h7E, 1'b0) && addr_match(8'h68, 7'h34, 7'h7E, 1'b0)
      && !addr_match(8'h6A, 7'h34, 7'h7F, 1'b0) && addr_match(8'h00, 7'h34, 7'h7F, 1'b1);
  endproperty
  a_mask_example: assert property (p_mask_example) else $error("match example wrong");

  property p_no_match;
    @(posedge clk) disable iff (!rst_n) ce && s_r.fsm == ST_SLV_BIT && scl_fall && !stop_det
      && !start_det && s_r.bitn == SMA_ACK_BIT && s_r.hw_ack_enable && !addr_match(s_r.shreg,
      s_r.own_address_field, s_r.address_mask_field, s_r.general_call_enable) |=>
      s_r.fsm == ST_IDLE && !s_r.sda_drv;
  endproperty
  a_no_match: assert property (p_no_match) else $error("unmatched address acked");
endmodule

// ### bench/sma_bus_partner.sv
// far-side bus party: acking slave, addressing master and a data-line jammer
`timescale 1ns/10ps
module sma_bus_partner (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // behaviour
  input wire logic ack_en,
  input wire logic jam,
  // drivers and last byte seen
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  logic s_ack = 1'b0;
  logic m_sda = 1'b0;
  logic [3:0] n = 4'h0;
  logic [7:0] sh = 8'h00;
  initial scl_oe = 1'b0;
  initial rx_byte = 8'h00;
  assign sda_oe = s_ack | m_sda | jam;
  // a start or repeated start restarts the bit count
  always @(negedge sda) begin
    if (scl) n = 4'h0;
  end
  always @(posedge scl) begin
    if (n < 4'h8) sh = {sh[6:0], sda};
    n = n + 4'h1;
  end
  always @(negedge scl) begin
    if (n == 4'h8) s_ack = ack_en;
    if (n == 4'h9) begin
      s_ack = 1'b0;
      n = 4'h0;
      rx_byte = sh;
    end
  end
  // the device may stretch the clock, so the wait is bounded rather than fixed
  task automatic wait_high();
    for (int w = 0; w < 400 && !scl; w++) #40;
    #40;
  endtask
  task automatic m_start();
    m_sda = 1'b1;
    #40 scl_oe = 1'b1;
    #40;
  endtask
  task automatic m_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #10 m_sda = !b[i];
      #30 scl_oe = 1'b0;
      #40 scl_oe = 1'b1;
    end
    #10 m_sda = 1'b0;
    #30 scl_oe = 1'b0;
    wait_high();
    ack = !sda;
    scl_oe = 1'b1;
    #40;
  endtask
  task automatic m_stop();
    #10 m_sda = 1'b1;
    #30 scl_oe = 1'b0;
    wait_high();
    m_sda = 1'b0;
    #40;
  endtask
  // hold scl low for a while, as a slow party stretching the clock would
  task automatic m_clamp();
    scl_oe = 1'b1;
    #100 scl_oe = 1'b0;
  endtask
endmodule

// ### bench/tb_top.sv
// self-checking bench: address match, master transmit sequencing, arbitration
`timescale 1ns/10ps
module tb_top;
  import sma_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic ack_en = 1'b0;
  logic jam = 1'b0;
  logic rd_d = 1'b0;
  sma_bus_req_t bus_req = '0;
  sma_pin_out_t pins;
  logic [7:0] rd_data;
  logic [7:0] p_byte;
  logic p_scl_oe;
  logic p_sda_oe;
  logic [7:0] exp_q[$];
  int failures = 0;
  int num_checks = 0;
  // open-drain wires with pull-ups
  wire scl_w = !(pins.scl_oe || p_scl_oe);
  wire sda_w = !(pins.sda_oe || p_sda_oe);
  // own reg, mask reg, address byte, expected ack
  logic [31:0] tbl[7] = '{32'h68FD6801, 32'h68FD6A01, 32'h68FD6C00, 32'h68FF6A00,
    32'h69FF0001, 32'h68FF0000, 32'h68FF6801};

  always #2.5 clk = ~clk;

  sma_smbus_core DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
    .rd_data(rd_data), .scl_i(scl_w), .sda_i(sda_w), .pins(pins));
  sma_bus_partner PEER (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .jam(jam),
    .scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .rx_byte(p_byte));

  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
  endtask
  // a bit half holds scl for 250 cycles, so 300 in a row means the flag holds the bus
  task automatic wait_held();
    int run;
    run = 0;
    for (int i = 0; i < 20000 && run < 300; i++) begin
      @(posedge clk);
      run = (pins.scl_oe === 1'b1) ? run + 1 : 0;
    end
    check1(run >= 300, 1'b1);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] st, input logic [7:0] cx);
    wr(SMA_A_CTRL, c);
    wait_held();
    rd(SMA_A_STAT, st);
    rd(SMA_A_CTRL, cx);
  endtask

  always @(posedge clk) begin
    rd_d <= bus_req.rd;
    if (rd_d) check8(rd_data, exp_q.pop_front());
  end

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    logic ack;
    logic [7:0] d;
    d = 8'($urandom(32'h714b));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(SMA_A_STAT, 8'h00);
    rd(SMA_A_CTRL, 8'h00);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    foreach (tbl[i]) begin
      wr(SMA_A_OWN, tbl[i][31:24]);
      wr(SMA_A_MASK, tbl[i][23:16]);
      rd(SMA_A_OWN, tbl[i][31:24]);
      PEER.m_start();
      PEER.m_byte(tbl[i][15:8], ack);
      check1(ack, tbl[i][0]);
      if (ack) begin
        rd(SMA_A_STAT, 8'h42);
        repeat (500) @(posedge clk);
        check1(pins.scl_oe, 1'b1);
        wr(SMA_A_CTRL, 8'h00);
      end
      PEER.m_stop();
      repeat (50) @(posedge clk);
      // an ignored address leaves the status of the last addressed stop in place
      rd(SMA_A_STAT, {4'h0, SMA_SV_SSTOP});
      rd(SMA_A_CTRL, ack ? 8'h01 : 8'h00);
      wr(SMA_A_CTRL, 8'h00);
    end
    wr(SMA_A_MASK, 8'hFE);
    step(8'h20, 8'hCE, 8'h21);
    ack_en <= 1'b1;
    wr(SMA_A_DATA, 8'hA4);
    step(8'h00, 8'hCC, 8'h03);
    check8(p_byte, 8'hA4);
    ack_en <= 1'b0;
    d = 8'($urandom());
    wr(SMA_A_DATA, d);
    step(8'h00, 8'hCC, 8'h01);
    check8(p_byte, d);
    ack_en <= 1'b1;
    step(8'h20, 8'hCE, 8'h21);
    wr(SMA_A_DATA, 8'hA4);
    step(8'h00, 8'hCC, 8'h03);
    step(8'h30, 8'hCE, 8'h31);
    wr(SMA_A_DATA, 8'hA5);
    step(8'h00, 8'hCC, 8'h03);
    ack_en <= 1'b0;
    step(8'h00, 8'hC8, 8'h09);
    rd(SMA_A_DATA, 8'hFF);
    wr(SMA_A_CTRL, 8'h10);
    repeat (3000) @(posedge clk);
    rd(SMA_A_STAT, 8'h00);
    rd(SMA_A_CTRL, 8'h10);
    step(8'h20, 8'hCE, 8'h21);
    wr(SMA_A_DATA, 8'hA4);
    jam <= 1'b1;
    wr(SMA_A_CTRL, 8'h00);
    repeat (2000) @(posedge clk);
    rd(SMA_A_CTRL, 8'h05);
    wr(SMA_A_CTRL, 8'h00);
    rd(SMA_A_CTRL, 8'h00);
    jam <= 1'b0;
    repeat (100) @(posedge clk);
    // with the clock enable low a write must leave no trace
    ce <= 1'b0;
    wr(SMA_A_CTRL, 8'h20);
    ce <= 1'b1;
    rd(SMA_A_CTRL, 8'h00);
    step(8'h20, 8'hCE, 8'h21);
    wr(SMA_A_CTRL, 8'h10);
    // let the stop release scl, then pull it low from the far side mid-stop
    wait (pins.scl_oe === 1'b0);
    repeat (20) @(posedge clk);
    PEER.m_clamp();
    rd(SMA_A_CTRL, 8'h15);
    rd(SMA_A_STAT, 8'h40);
    wr(SMA_A_CTRL, 8'h00);
    rd(SMA_A_CTRL, 8'h00);
    repeat (20) @(posedge clk);
    report_and_stop();
  end
endmodule
